// ===== dv/rfbi_asserts.sv
// Port checker for rfbi_top.
// Assumes one clock and synchronous active-high reset.

`timescale 1ns/1ps
`default_nettype none

module rfbi_asserts (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       rst,
  // Register and request side
  input wire logic                       reg_rd,
  input wire logic [31:0]                reg_rdata,
  input wire logic                       req_claim,
  input wire logic                       req_write,
  input wire logic [rfbi_pkg::LEN_W-1:0] req_len,
  input wire logic                       req_busy,
  input wire logic                       req_done,
  // Device pins
  input wire logic [rfbi_pkg::NBLK-1:0]  rom_ce_n,
  input wire logic                       rom_oe_n,
  input wire logic                       rom_we_n,
  input wire logic                       rom_upper_n,
  input wire logic                       rom_lower_n,
  input wire logic                       rom_dq_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_one_block: assert property ($onehot0(~rom_ce_n)) else $error("two blocks selected");
  a_rd_wr_excl: assert property (!(!rom_we_n && !rom_oe_n)) else $error("read and write together");
  a_wr_drive: assert property (!rom_we_n |-> rom_dq_oe && rom_ce_n != 2'b11)
    else $error("write without data drive");
  a_wr_one_half: assert property (!rom_we_n |-> rom_upper_n != rom_lower_n)
    else $error("write select count wrong");
  a_rd_start: assert property (req_claim && !req_write |=> !rom_oe_n && req_busy)
    else $error("read access not started");
  a_wr_drop: assert property (req_claim && req_write && req_len != 6'h01 && req_len != 6'h04
    |=> req_done && rom_we_n) else $error("bad write size not dropped");
  a_acc_min: assert property ($fell(rom_oe_n) |-> !rom_oe_n [*3]) else $error("access too short");
  a_done_idle: assert property (req_done |-> !req_busy && rom_oe_n && rom_we_n)
    else $error("done while active");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray read data");

  c_read: cover property (req_claim && !req_write);
  c_write: cover property (!rom_we_n);
  c_drop: cover property (req_claim && req_write ##1 req_done);
endmodule

bind rfbi_top rfbi_asserts u_asserts (.clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .req_claim(req_claim), .req_write(req_write), .req_len(req_len), .req_busy(req_busy),
  .req_done(req_done), .rom_ce_n(rom_ce_n), .rom_oe_n(rom_oe_n), .rom_we_n(rom_we_n),
  .rom_upper_n(rom_upper_n), .rom_lower_n(rom_lower_n), .rom_dq_oe(rom_dq_oe));

`default_nettype wire

// ===== dv/rfbi_rom_model.sv
// Behavioural pair of ROM/Flash devices on both blocks' pins.
// Assumes pins from rfbi_top; read data is a fixed pattern of the device address.

`timescale 1ns/1ps
`default_nettype none

module rfbi_rom_model (
  // Clock
  input  wire logic        clk,
  // Device pins
  input  wire logic [1:0]  rom_ce_n,
  input  wire logic        rom_oe_n,
  input  wire logic        rom_we_n,
  input  wire logic        rom_upper_n,
  input  wire logic        rom_lower_n,
  input  wire logic [22:0] rom_addr,
  input  wire logic [63:0] rom_dq_o,
  input  wire logic        rom_dq_oe,
  output logic [63:0]      rom_dq_i,
  // Answer delay and write log
  input  wire logic [1:0]  dly,
  output logic [22:0]      wr_addr,
  output logic [63:0]      wr_data,
  output logic [1:0]       wr_sel,
  output logic [7:0]       wr_cnt
);
  logic [1:0]  age;
  logic [63:0] last;
  logic [63:0] pv;
  logic        rd;
  logic        wp;

  assign rd = !rom_oe_n && (rom_ce_n != 2'b11);
  assign pv = {8{rom_addr[7:0] ^ rom_addr[22:15]}} ^ 64'h00112233_44556677;

  // Each half answers only when selected and after the access delay; otherwise a changing value
  always_comb
  begin
    rom_dq_i = ~last;
    if (rd && age >= dly && !rom_upper_n)
      rom_dq_i[63:32] = pv[63:32];
    if (rd && age >= dly && !rom_lower_n)
      rom_dq_i[31:0] = pv[31:0];
  end

  initial
  begin
    age = 2'h0;
    last = 64'h0;
    wp = 1'b0;
    wr_cnt = 8'h0;
  end

  always @(posedge clk)
  begin
    age <= !rd ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
    last <= rom_dq_i;
    wp <= !rom_we_n;
    if (!rom_we_n && rom_dq_oe)
    begin
      wr_addr <= rom_addr;
      wr_data <= rom_dq_o;
      wr_sel <= {!rom_upper_n, !rom_lower_n};
    end
    if (wp && rom_we_n)
      wr_cnt <= wr_cnt + 8'h1;
  end
endmodule

`default_nettype wire

// ===== dv/tb.sv
// Testbench for rfbi_top with the device model on its pins.
// Assumes block A narrow with boot jumper, block B wide.

`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk, rst, ce, reg_wr, reg_rd, req_valid, req_write, req_claim, req_busy, req_done, rd_beat;
  logic rom_oe_n, rom_we_n, rom_upper_n, rom_lower_n, rom_dq_oe;
  logic [7:0]  reg_addr, wr_cnt;
  logic [31:0] reg_wdata, reg_rdata, req_addr;
  logic [5:0]  req_len;
  logic [63:0] req_wdata, rd_data, rom_dq_o, rom_dq_i, wr_data;
  logic [1:0]  strap_rven, strap_wide, rom_ce_n, wr_sel, dly;
  logic [22:0] rom_addr, wr_addr;
  logic [63:0] beats [0:3];
  int          nb, oecnt, mismatches, comparisons;

  rfbi_top DUT (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
    .req_addr(req_addr), .req_write(req_write), .req_len(req_len), .req_wdata(req_wdata),
    .req_claim(req_claim), .req_busy(req_busy), .req_done(req_done), .rd_beat(rd_beat),
    .rd_data(rd_data), .strap_rven(strap_rven), .strap_wide(strap_wide), .rom_ce_n(rom_ce_n),
    .rom_oe_n(rom_oe_n), .rom_we_n(rom_we_n), .rom_upper_n(rom_upper_n), .rom_lower_n(rom_lower_n),
    .rom_addr(rom_addr), .rom_dq_o(rom_dq_o), .rom_dq_oe(rom_dq_oe), .rom_dq_i(rom_dq_i));

  rfbi_rom_model u_rom (.clk(clk), .rom_ce_n(rom_ce_n), .rom_oe_n(rom_oe_n), .rom_we_n(rom_we_n),
    .rom_upper_n(rom_upper_n), .rom_lower_n(rom_lower_n), .rom_addr(rom_addr), .rom_dq_o(rom_dq_o),
    .rom_dq_oe(rom_dq_oe), .rom_dq_i(rom_dq_i), .dly(dly), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_sel(wr_sel), .wr_cnt(wr_cnt));

  always #12.5 clk = ~clk;

  // Beat capture and read access length
  always @(posedge clk)
  begin
    if (rd_beat && nb < 4)
      beats[nb] <= rd_data;
    if (rd_beat)
      nb <= nb + 1;
    if (!rom_oe_n)
      oecnt <= oecnt + 1;
  end

  function automatic logic [63:0] pat(input logic [7:0] a);
    return {8{a}} ^ 64'h00112233_44556677;
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({32'h0, reg_rdata}, {32'h0, exp});
  endtask

  task automatic req(input logic [31:0] a, input logic w, input logic [5:0] n, input logic c);
    int i;
    @(posedge clk);
    req_valid <= 1'b1;
    req_addr <= a;
    req_write <= w;
    req_len <= n;
    nb <= 0;
    oecnt <= 0;
    #1;
    chk({63'h0, req_claim}, {63'h0, c});
    @(posedge clk);
    req_valid <= 1'b0;
    for (i = 0; i < 300 && c && !req_done; i++)
      @(posedge clk);
    if (c)
      chk(64'(i < 300), 64'h1);
    #1;
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    mismatches++;
    end_of_test;
  end

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    {reg_wr, reg_rd, req_valid, req_write} = 4'h0;
    {reg_addr, reg_wdata, req_addr, req_len, dly} = '0;
    req_wdata = 64'h00112233_44556677;
    strap_rven = 2'b01;
    strap_wide = 2'b10;
    nb = 0;
    oecnt = 0;
    mismatches = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    rd_reg(8'h00, 32'h00000f04);
    rd_reg(8'h04, 32'h00000f08);
    rd_reg(8'h08, 32'hff000000);
    rd_reg(8'h0c, 32'hff400000);
    rd_reg(8'h20, 32'h00000000);
    req(32'hff000000, 1'b0, 6'h01, 1'b0);
    req(32'hfff00003, 1'b0, 6'h01, 1'b1);
    chk(rd_data, 64'h00000030_00000000);
    wr_reg(8'h00, 32'h0000000f);
    rd_reg(8'h00, 32'h00000007);
    req(32'hff000003, 1'b0, 6'h02, 1'b1);
    chk(rd_data, 64'h00000030_77000000);
    chk(64'(oecnt), 64'h6);
    req(32'hff00000d, 1'b1, 6'h01, 1'b1);
    chk(64'({wr_sel, wr_addr, wr_data[7:0]}), 64'({2'b01, 23'h5, 8'h55}));
    req(32'hff00000d, 1'b1, 6'h02, 1'b1);
    chk(64'(wr_cnt), 64'h1);
    rd_reg(8'h10, 32'h00000002);
    wr_reg(8'h10, 32'h00000002);
    rd_reg(8'h10, 32'h00000000);
    req(32'hff200005, 1'b0, 6'h01, 1'b0);
    wr_reg(8'h00, 32'h00000021);
    req(32'hff200005, 1'b0, 6'h01, 1'b1);
    chk(rd_data, 64'h00000000_00560000);
    wr_reg(8'h04, 32'h00000401);
    req(32'hff400014, 1'b1, 6'h04, 1'b1);
    chk(64'(wr_cnt), 64'h1);
    rd_reg(8'h10, 32'h00000002);
    wr_reg(8'h10, 32'h00000002);
    wr_reg(8'h04, 32'h00000403);
    rd_reg(8'h04, 32'h0000040b);
    req(32'hff400010, 1'b0, 6'h08, 1'b1);
    chk(rd_data, pat(8'h02));
    chk(64'(oecnt), 64'h7);
    req(32'hff400020, 1'b0, 6'h20, 1'b1);
    chk(64'(nb), 64'h4);
    for (int i = 0; i < 4; i++)
      chk(beats[i], pat(8'(4 + i)));
    req(32'hff400014, 1'b1, 6'h04, 1'b1);
    chk(64'({wr_sel, wr_addr, wr_data[31:0]}), 64'({2'b01, 23'h2, 32'h44556677}));
    req(32'hff400016, 1'b1, 6'h04, 1'b1);
    chk(64'(wr_cnt), 64'h2);
    rd_reg(8'h10, 32'h00000002);
    wr_reg(8'h0c, 32'hff800000);
    rd_reg(8'h0c, 32'hff800000);
    dly = 2'h3;
    req(32'hff400010, 1'b0, 6'h08, 1'b0);
    req(32'hff800008, 1'b0, 6'h08, 1'b1);
    chk(rd_data, pat(8'h01));
    end_of_test;
  end
endmodule

`default_nettype wire

// ===== rtl/rfbi_dec.sv
// Address decoder for one ROM/Flash block: base window and boot window.
// Assumes base is aligned to the programmed size.

`timescale 1ns/1ps
`default_nettype none

module rfbi_dec (
  // Processor address
  input  wire logic [31:0]                  addr,
  // Block settings
  input  wire logic [rfbi_pkg::BASE_W-1:0]  base,
  input  wire logic [rfbi_pkg::SIZE_W-1:0]  size,
  input  wire logic                         en,
  input  wire logic                         rven,
  // Decode result
  output logic                              hit,
  output logic [rfbi_pkg::OFS_W-1:0]        ofs
);

  localparam int MW = rfbi_pkg::OFS_W - rfbi_pkg::PAGE_LSB;
  localparam int BL = rfbi_pkg::OFS_W - rfbi_pkg::BASE_LSB;
  localparam int PL = rfbi_pkg::BASE_LSB - rfbi_pkg::PAGE_LSB;

  logic [MW-1:0] mask;
  logic [MW-1:0] pdiff;
  logic          top_eq;
  logic          base_hit;
  logic          boot_hit;

  // Megabyte pages below the size are free offset bits
  assign mask     = {MW{1'b1}} << size;
  assign pdiff    = addr[rfbi_pkg::OFS_W-1:rfbi_pkg::PAGE_LSB] ^ {base[BL-1:0], {PL{1'b0}}};
  assign top_eq   = addr[31:rfbi_pkg::OFS_W] == base[rfbi_pkg::BASE_W-1:BL];
  assign base_hit = top_eq && ((pdiff & mask) == '0);
  assign boot_hit = rven && (addr[31:rfbi_pkg::PAGE_LSB] == rfbi_pkg::BOOT_PAGE);
  assign hit      = boot_hit || (base_hit && en);
  assign ofs      = boot_hit ? {{MW{1'b0}}, addr[rfbi_pkg::PAGE_LSB-1:0]}
                             : {pdiff & ~mask, addr[rfbi_pkg::PAGE_LSB-1:0]};

endmodule

`default_nettype wire

// ===== rtl/rfbi_pkg.sv
// Constants, register layout and state codes of the ROM/Flash block interface.
// Assumes one 40 MHz clock, synchronous active-high reset and a 32-bit register port.

`default_nettype none

package rfbi_pkg;

  // Geometry
  localparam int NBLK     = 2;
  localparam int OFS_W    = 26;
  localparam int RA_W     = 23;
  localparam int PAGE_LSB = 20;
  localparam int BASE_LSB = 22;
  localparam int BASE_W   = 32 - BASE_LSB;
  localparam int SIZE_W   = 3;
  localparam int ATIME_W  = 4;
  localparam int TMR_W    = 5;
  localparam int LEN_W    = 6;
  localparam int DW_SH    = 3;
  localparam int UPH_LSB  = 32;
  localparam int LOH_LSB  = 0;

  // Register offsets
  localparam logic [7:0] REG_CTRL0  = 8'h00;
  localparam logic [7:0] REG_BASE0  = 8'h08;
  localparam logic [7:0] REG_STRIDE = 8'h04;
  localparam logic [7:0] REG_STAT   = 8'h10;

  // Control register fields
  localparam int CF_EN    = 0;
  localparam int CF_WEN   = 1;
  localparam int CF_RVEN  = 2;
  localparam int CF_WIDE  = 3;
  localparam int CF_SIZE  = 4;
  localparam int CF_ATIME = 8;

  // Status register fields
  localparam int SF_BUSY = 0;
  localparam int SF_IGN  = 1;

  // Reset values
  localparam logic [BASE_W-1:0]  BASE_RST_A = 10'h3fc;
  localparam logic [BASE_W-1:0]  BASE_RST_B = 10'h3fd;
  localparam logic [SIZE_W-1:0]  SIZE_RST   = 3'h0;
  localparam logic [ATIME_W-1:0] ATIME_RST  = 4'hf;

  // Boot window page
  localparam logic [31-PAGE_LSB:0] BOOT_PAGE = 12'hfff;

  // Transfer lengths in bytes
  localparam logic [LEN_W-1:0] LEN_ONE   = 6'h01;
  localparam logic [LEN_W-1:0] LEN_WORD  = 6'h04;
  localparam logic [LEN_W-1:0] LEN_DWORD = 6'h08;

  // Cycles for pin data to pass the synchroniser
  localparam logic [TMR_W-1:0] SYNC_LAT   = 5'h02;
  localparam logic [1:0]       STRAP_WAIT = 2'h2;

  typedef enum logic [1:0] {
    ST_STRAP = 2'b00,
    ST_IDLE  = 2'b01,
    ST_ACC   = 2'b10
  } rfbi_state_t;

endpackage

`default_nettype wire

// ===== rtl/rfbi_top.sv
// ROM/Flash block interface: register port, bus request decode and device sequencer.
// Assumes bus requests, register port and clock enable come from logic on clk;
// jumpers and device data are pins and are synchronised here.
//
// Added by the designer: the register addresses and the plain strobed port.

`timescale 1ns/1ps
`default_nettype none

module rfbi_top (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           ce,
  // Register port
  input  wire logic [7:0]                     reg_addr,
  input  wire logic [31:0]                    reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic [31:0]                         reg_rdata,
  // Processor bus requests
  input  wire logic                           req_valid,
  input  wire logic [31:0]                    req_addr,
  input  wire logic                           req_write,
  input  wire logic [rfbi_pkg::LEN_W-1:0]     req_len,
  input  wire logic [63:0]                    req_wdata,
  output logic                                req_claim,
  output logic                                req_busy,
  output logic                                req_done,
  output logic                                rd_beat,
  output logic [63:0]                         rd_data,
  // Jumpers
  input  wire logic [rfbi_pkg::NBLK-1:0]      strap_rven,
  input  wire logic [rfbi_pkg::NBLK-1:0]      strap_wide,
  // ROM/Flash pins
  output logic [rfbi_pkg::NBLK-1:0]           rom_ce_n,
  output logic                                rom_oe_n,
  output logic                                rom_we_n,
  output logic                                rom_upper_n,
  output logic                                rom_lower_n,
  output logic [rfbi_pkg::RA_W-1:0]           rom_addr,
  output logic [63:0]                         rom_dq_o,
  output logic                                rom_dq_oe,
  input  wire logic [63:0]                    rom_dq_i
);

  localparam int NB = rfbi_pkg::NBLK;

  // Per-block settings
  logic                             en_r    [NB];
  logic                             wen_r   [NB];
  logic                             rven_r  [NB];
  logic                             wide_r  [NB];
  logic [rfbi_pkg::SIZE_W-1:0]      size_r  [NB];
  logic [rfbi_pkg::ATIME_W-1:0]     atime_r [NB];
  logic [rfbi_pkg::BASE_W-1:0]      base_r  [NB];
  logic [31:0]                      ctrl_word [NB];
  logic [31:0]                      base_word [NB];
  logic [NB-1:0]                    wr_ctrl;
  logic [NB-1:0]                    wr_base;
  logic [NB-1:0]                    rd_ctrl;
  logic [NB-1:0]                    rd_base;
  logic [NB-1:0]                    hit;
  logic [rfbi_pkg::OFS_W-1:0]       ofs     [NB];

  // Synchronisers
  logic [NB-1:0]                    srv_m_r;
  logic [NB-1:0]                    srv_s_r;
  logic [NB-1:0]                    swd_m_r;
  logic [NB-1:0]                    swd_s_r;
  logic [63:0]                      dq_m_r;
  logic [63:0]                      dq_s_r;

  // Sequencer state
  rfbi_pkg::rfbi_state_t            st_r;
  rfbi_pkg::rfbi_state_t            st_nxt;
  logic [1:0]                       scnt_r;
  logic [1:0]                       scnt_nxt;
  logic                             blk_r;
  logic                             wr_r;
  logic [rfbi_pkg::OFS_W-1:0]       off_r;
  logic [rfbi_pkg::OFS_W-1:0]       off_nxt;
  logic [rfbi_pkg::LEN_W-1:0]       left_r;
  logic [rfbi_pkg::LEN_W-1:0]       left_nxt;
  logic [rfbi_pkg::TMR_W-1:0]       tmr_r;
  logic [rfbi_pkg::TMR_W-1:0]       tmr_nxt;
  logic [63:0]                      wdata_r;
  logic [63:0]                      wdata_nxt;
  logic [63:0]                      rdata_r;
  logic [63:0]                      rdata_nxt;
  logic                             beat_nxt;
  logic                             done_nxt;
  logic                             ign_r;
  logic [31:0]                      rdata_reg_r;
  logic [31:0]                      rdata_reg_nxt;

  // Decode wires
  logic                             strap_take;
  logic                             sel;
  logic                             any_hit;
  logic                             wide_sel;
  logic                             wr_ok;
  logic                             go_rd;
  logic                             go_wr;
  logic                             drop_wr;
  logic                             acc;
  logic                             acc_end;
  logic                             acc_wide;
  logic                             last;
  logic                             lane_end;
  logic [rfbi_pkg::LEN_W-1:0]       acc_n;
  logic [rfbi_pkg::OFS_W-1:0]       step;
  logic [rfbi_pkg::TMR_W-1:0]       tmr_load;
  logic [rfbi_pkg::TMR_W-1:0]       tmr_start;
  logic [7:0]                       nbyte;
  logic [7:0]                       wbyte;
  logic [31:0]                      wword;
  logic                             wr_stat;
  logic                             rd_stat;

  // Jumper capture runs once, after the synchroniser has filled
  assign strap_take = (st_r == rfbi_pkg::ST_STRAP) && (scnt_r == rfbi_pkg::STRAP_WAIT);

  genvar i;
  generate
    for (i = 0; i < NB; i++)
    begin : g_blk
      assign wr_ctrl[i] = reg_wr && (reg_addr == 8'(rfbi_pkg::REG_CTRL0 + i * rfbi_pkg::REG_STRIDE));
      assign wr_base[i] = reg_wr && (reg_addr == 8'(rfbi_pkg::REG_BASE0 + i * rfbi_pkg::REG_STRIDE));
      assign rd_ctrl[i] = reg_rd && (reg_addr == 8'(rfbi_pkg::REG_CTRL0 + i * rfbi_pkg::REG_STRIDE));
      assign rd_base[i] = reg_rd && (reg_addr == 8'(rfbi_pkg::REG_BASE0 + i * rfbi_pkg::REG_STRIDE));
      assign ctrl_word[i] = 32'({atime_r[i], 1'b0, size_r[i], wide_r[i], rven_r[i], wen_r[i], en_r[i]});
      assign base_word[i] = {base_r[i], {rfbi_pkg::BASE_LSB{1'b0}}};

      rfbi_dec u_dec (
        .addr (req_addr),
        .base (base_r[i]),
        .size (size_r[i]),
        .en   (en_r[i]),
        .rven (rven_r[i]),
        .hit  (hit[i]),
        .ofs  (ofs[i])
      );

      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          en_r[i]    <= 1'b0;
          wen_r[i]   <= 1'b0;
          rven_r[i]  <= 1'b0;
          wide_r[i]  <= 1'b0;
          size_r[i]  <= rfbi_pkg::SIZE_RST;
          atime_r[i] <= rfbi_pkg::ATIME_RST;
          base_r[i]  <= (i == 0) ? rfbi_pkg::BASE_RST_A : rfbi_pkg::BASE_RST_B;
        end
        else if (ce)
        begin
          if (strap_take)
          begin
            rven_r[i] <= srv_s_r[i];
            wide_r[i] <= swd_s_r[i];
          end
          else if (wr_ctrl[i])
          begin
            rven_r[i] <= reg_wdata[rfbi_pkg::CF_RVEN];
          end
          if (wr_ctrl[i])
          begin
            en_r[i]    <= reg_wdata[rfbi_pkg::CF_EN];
            wen_r[i]   <= reg_wdata[rfbi_pkg::CF_WEN];
            size_r[i]  <= reg_wdata[rfbi_pkg::CF_SIZE +: rfbi_pkg::SIZE_W];
            atime_r[i] <= reg_wdata[rfbi_pkg::CF_ATIME +: rfbi_pkg::ATIME_W];
          end
          if (wr_base[i])
          begin
            base_r[i] <= reg_wdata[31:rfbi_pkg::BASE_LSB];
          end
        end
      end
    end
  endgenerate

  // Register read data, one cycle after the strobe
  assign wr_stat = reg_wr && (reg_addr == rfbi_pkg::REG_STAT);
  assign rd_stat = reg_rd && (reg_addr == rfbi_pkg::REG_STAT);
  assign rdata_reg_nxt = rd_ctrl[0] ? ctrl_word[0] :
                         rd_ctrl[1] ? ctrl_word[1] :
                         rd_base[0] ? base_word[0] :
                         rd_base[1] ? base_word[1] :
                         rd_stat    ? 32'({ign_r, req_busy}) : '0;
  assign reg_rdata = rdata_reg_r;

  // Request decode, block A first
  assign any_hit   = |hit;
  assign sel       = !hit[0];
  assign wide_sel  = wide_r[sel];
  assign req_busy  = st_r != rfbi_pkg::ST_IDLE;
  assign req_claim = ce && req_valid && !req_busy && any_hit;
  assign wr_ok     = wen_r[sel] && (wide_sel ? (req_len == rfbi_pkg::LEN_WORD) && (req_addr[1:0] == 2'h0)
                                             : (req_len == rfbi_pkg::LEN_ONE));
  assign go_rd     = req_claim && !req_write;
  assign go_wr     = req_claim && req_write && wr_ok;
  assign drop_wr   = req_claim && req_write && !wr_ok;

  // Accesses per request: one per byte narrow, one per doubleword wide
  assign acc_n = req_write ? rfbi_pkg::LEN_ONE :
                 !wide_sel ? req_len :
                 (req_len > rfbi_pkg::LEN_DWORD) ? (req_len >> rfbi_pkg::DW_SH) : rfbi_pkg::LEN_ONE;

  // Write data placed on the halves
  assign wbyte = req_wdata[{~req_addr[2:0], 3'h0} +: 8];
  assign wword = req_addr[2] ? req_wdata[31:0] : req_wdata[63:32];

  // Device cycle timing
  assign tmr_load  = rfbi_pkg::TMR_W'(atime_r[blk_r]) + rfbi_pkg::SYNC_LAT;
  assign tmr_start = rfbi_pkg::TMR_W'(atime_r[sel]) + rfbi_pkg::SYNC_LAT;
  assign acc       = st_r == rfbi_pkg::ST_ACC;
  assign acc_end   = acc && (tmr_r == '0);
  assign acc_wide  = wide_r[blk_r];
  assign last      = left_r == rfbi_pkg::LEN_ONE;
  assign lane_end  = acc_wide || (off_r[2:0] == 3'h7) || last;
  assign step      = acc_wide ? rfbi_pkg::OFS_W'(rfbi_pkg::LEN_DWORD) : rfbi_pkg::OFS_W'(rfbi_pkg::LEN_ONE);
  assign nbyte     = off_r[2] ? dq_s_r[rfbi_pkg::LOH_LSB +: 8] : dq_s_r[rfbi_pkg::UPH_LSB +: 8];

  always_comb
  begin
    st_nxt    = st_r;
    scnt_nxt  = scnt_r;
    off_nxt   = off_r;
    left_nxt  = left_r;
    tmr_nxt   = tmr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    beat_nxt  = 1'b0;
    done_nxt  = 1'b0;
    unique case (st_r)
      rfbi_pkg::ST_STRAP:
      begin
        scnt_nxt = scnt_r + 2'h1;
        if (strap_take)
          st_nxt = rfbi_pkg::ST_IDLE;
      end
      rfbi_pkg::ST_IDLE:
      begin
        if (drop_wr)
          done_nxt = 1'b1;
        if (go_rd || go_wr)
        begin
          st_nxt    = rfbi_pkg::ST_ACC;
          off_nxt   = ofs[sel];
          left_nxt  = acc_n;
          tmr_nxt   = tmr_start;
          rdata_nxt = '0;
          wdata_nxt = wide_sel ? {wword, wword} : {24'h0, wbyte, 24'h0, wbyte};
        end
      end
      rfbi_pkg::ST_ACC:
      begin
        if (!acc_end)
          tmr_nxt = tmr_r - 5'h01;
        else
        begin
          if (!wr_r)
          begin
            if (acc_wide)
              rdata_nxt = dq_s_r;
            else
              rdata_nxt[{~off_r[2:0], 3'h0} +: 8] = nbyte;
            beat_nxt = lane_end;
          end
          left_nxt = left_r - rfbi_pkg::LEN_ONE;
          off_nxt  = off_r + step;
          tmr_nxt  = tmr_load;
          if (last)
          begin
            done_nxt = 1'b1;
            st_nxt   = rfbi_pkg::ST_IDLE;
          end
        end
      end
      default:
        st_nxt = rfbi_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r        <= rfbi_pkg::ST_STRAP;
      scnt_r      <= 2'h0;
      blk_r       <= 1'b0;
      wr_r        <= 1'b0;
      off_r       <= '0;
      left_r      <= '0;
      tmr_r       <= '0;
      wdata_r     <= '0;
      rdata_r     <= '0;
      rd_beat     <= 1'b0;
      req_done    <= 1'b0;
      ign_r       <= 1'b0;
      rdata_reg_r <= '0;
      srv_m_r     <= '0;
      srv_s_r     <= '0;
      swd_m_r     <= '0;
      swd_s_r     <= '0;
      dq_m_r      <= '0;
      dq_s_r      <= '0;
    end
    else if (ce)
    begin
      st_r        <= st_nxt;
      scnt_r      <= scnt_nxt;
      off_r       <= off_nxt;
      left_r      <= left_nxt;
      tmr_r       <= tmr_nxt;
      wdata_r     <= wdata_nxt;
      rdata_r     <= rdata_nxt;
      rd_beat     <= beat_nxt;
      req_done    <= done_nxt;
      rdata_reg_r <= rdata_reg_nxt;
      srv_m_r     <= strap_rven;
      srv_s_r     <= srv_m_r;
      swd_m_r     <= strap_wide;
      swd_s_r     <= swd_m_r;
      dq_m_r      <= rom_dq_i;
      dq_s_r      <= dq_m_r;
      if (req_claim)
      begin
        blk_r <= sel;
        wr_r  <= req_write;
      end
      // Set wins over a same-cycle clear
      if (drop_wr)
        ign_r <= 1'b1;
      else if (wr_stat && reg_wdata[rfbi_pkg::SF_IGN])
        ign_r <= 1'b0;
    end
  end

  // ROM/Flash pins
  assign rd_data     = rdata_r;
  assign rom_ce_n    = ~({blk_r, !blk_r} & {NB{acc}});
  assign rom_oe_n    = !(acc && !wr_r);
  assign rom_we_n    = !(acc && wr_r);
  assign rom_upper_n = !(acc && ((acc_wide && !wr_r) || !off_r[2]));
  assign rom_lower_n = !(acc && ((acc_wide && !wr_r) || off_r[2]));
  assign rom_addr    = acc_wide ? off_r[rfbi_pkg::OFS_W-1:rfbi_pkg::DW_SH]
                                : {off_r[rfbi_pkg::RA_W:rfbi_pkg::DW_SH], off_r[1:0]};
  assign rom_dq_o    = wdata_r;
  assign rom_dq_oe   = acc && wr_r;

endmodule

`default_nettype wire
